// ---- core/acp_pkg.sv ----
// Package for the action-command scheduler with time synchronisation.
// Assumes a 20 MHz system clock and an AXI4-Lite register bus of 32 bits.
package acp_pkg;

	// Clock and timing
	localparam int          CLK_PERIOD_NS   = 50;
	localparam int          CLK_MHZ         = 20;
	localparam int          SYNC_PERIOD_US  = 1000;
	localparam int          SYNC_PERIOD_CYC = SYNC_PERIOD_US * CLK_MHZ;
	localparam logic [63:0] NS_STEP         = 64'(CLK_PERIOD_NS);

	// Queue and bus geometry
	localparam int QUEUE_DEPTH = 4;
	localparam int ADDR_W      = 8;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_UNIT_KEY  = 8'h08;
	localparam logic [7:0] OFS_GRP_KEY   = 8'h0C;
	localparam logic [7:0] OFS_GRP_MASK  = 8'h10;
	localparam logic [7:0] OFS_ENTRY_IDX = 8'h14;
	localparam logic [7:0] OFS_Q_DEPTH   = 8'h18;
	localparam logic [7:0] OFS_CAP_LO    = 8'h1C;
	localparam logic [7:0] OFS_CAP_HI    = 8'h20;
	localparam logic [7:0] OFS_OWN_QUAL  = 8'h24;
	localparam logic [7:0] OFS_PATH_DLY  = 8'h28;
	localparam logic [7:0] OFS_DROP_CNT  = 8'h2C;

	// Control register fields
	localparam int BIT_SYNC_EN = 0;
	localparam int BIT_CLEAR   = 1;
	localparam int BIT_CAPTURE = 2;

	// Reset values
	localparam logic [7:0]  RST_OWN_QUAL = 8'h80;
	localparam logic [31:0] RST_KEY      = 32'h0000_0000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Synchronisation exchange states, one bit changes per step except the return from ACP_WAIT_RESP to ACP_IDLE
	typedef enum logic [1:0] {
		ACP_IDLE      = 2'b00,
		ACP_WAIT_SYNC = 2'b01,
		ACP_WAIT_RESP = 2'b11
	} acp_sync_t;

endpackage

// ---- core/acp_sched.sv ----
// Action-command filter, scheduled trigger queue and synchronised time counter.
// Assumes link-side parsers on the same clock deliver decoded messages as pulses.
//
// Overview of operation
// (RULE1) Act only when group keys match
// (RULE2) Masks ANDed; any set bit executes
// (RULE3) Entry index fixed, reads zero
// (RULE4) Queue size readable as integer
// (RULE5) Keep time counter synced to master
// (RULE6) Best-master selection picks best clock
// (RULE7) Equal quality: smallest MAC wins
// (RULE8) Path delay from exchanged message timestamps
// (RULE9) Slave corrects its clock by offset
// (RULE10) Exchange repeats periodically against drift
// (RULE11) Synchronisation idle unless enabled
// (RULE12) Ready for commands only when synced
// (RULE13) Untimed command exposes at once
// (RULE14) Timed command queued, fires at time
// (RULE15) Host configures keys before commanding
// (RULE16) Clear command zeroes time counter; a delay response applied in the same cycle overrides it
// (RULE17) Capture copies counter to holding register
// (RULE18) Unit key mismatch discards command first
// (RULE19) Full queue drops new timed command
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module acp_sched #(
	parameter int QD         = acp_pkg::QUEUE_DEPTH,
	parameter int PERIOD_CYC = acp_pkg::SYNC_PERIOD_CYC
) (
	// Clock and reset
	input  wire logic                       clock,
	input  wire logic                       srst,
	// AXI4-Lite write address and data
	input  wire logic [acp_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	// AXI4-Lite read
	input  wire logic [acp_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	// Clock quality announcements
	input  wire logic                       ann_valid,
	input  wire logic [7:0]                 ann_quality,
	input  wire logic [47:0]                ann_mac,
	input  wire logic [47:0]                own_mac,
	// Synchronisation messages
	input  wire logic                       sync_valid,
	input  wire logic [63:0]                sync_origin,
	input  wire logic                       resp_valid,
	input  wire logic [63:0]                resp_time,
	output logic                            delay_req_send,
	// Action commands
	input  wire logic                       cmd_valid,
	input  wire logic [31:0]                cmd_unit_key,
	input  wire logic [31:0]                cmd_group_key,
	input  wire logic [31:0]                cmd_group_mask,
	input  wire logic                       cmd_has_time,
	input  wire logic [63:0]                cmd_time,
	// Status and trigger
	output logic                            action_ready,
	output logic                            exposure_start,
	output logic                            is_master,
	output logic [63:0]                     time_now
);
	import acp_pkg::*;

	typedef struct packed {
		logic                  aw_hold;
		logic [ADDR_W-1:0]     aw_addr;
		logic                  w_hold;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic                  sync_en;
		logic [31:0]           unit_key;
		logic [31:0]           grp_key;
		logic [31:0]           grp_mask;
		logic [7:0]            own_qual;
		logic [63:0]           now;
		logic [63:0]           captured;
		acp_sync_t             st;
		logic [31:0]           period_cnt;
		logic [63:0]           t1;
		logic [63:0]           t2;
		logic [63:0]           t3;
		logic [31:0]           path_dly;
		logic                  synced;
		logic                  best_vld;
		logic [7:0]            best_qual;
		logic [47:0]           best_mac;
		logic [QD-1:0]         q_vld;
		logic [QD-1:0][63:0]   q_time;
		logic                  expose;
		logic                  dreq;
		logic [31:0]           drop_cnt;
	} acp_state_t;

	acp_state_t s_ff;
	acp_state_t nxt_s;

	// Byte-lane merge for writable registers
	function automatic logic [31:0] acp_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Lower quality figure wins; on a tie the smaller MAC
	function automatic logic acp_better(input logic [7:0] qa, input logic [47:0] ma,
		input logic [7:0] qb, input logic [47:0] mb);
		return (qa < qb) || ((qa == qb) && (ma < mb));
	endfunction

	// Wrap-safe comparison of time against a target
	function automatic logic acp_reached(input logic [63:0] now_v, input logic [63:0] tgt);
		logic [63:0] diff;
		diff = now_v - tgt;
		return !diff[63];
	endfunction

	logic          master_role;
	logic          unit_ok;
	logic          group_ok;
	logic          mask_ok;
	logic          acc;
	logic          q_full;
	logic [31:0]   free_cnt;
	logic          wr_fire;
	logic [7:0]    wr_ofs;
	logic [7:0]    rd_ofs;
	logic          q_idle;

	// Master when nobody better has announced itself
	assign master_role = !s_ff.best_vld ||
		acp_better(s_ff.own_qual, own_mac, s_ff.best_qual, s_ff.best_mac); // see (RULE6) (RULE7)

	// Command filtering chain
	assign unit_ok  = (cmd_unit_key == s_ff.unit_key);        // see (RULE18)
	assign group_ok = (cmd_group_key == s_ff.grp_key);        // see (RULE1)
	assign mask_ok  = |(cmd_group_mask & s_ff.grp_mask);      // see (RULE2)
	assign acc      = cmd_valid && s_ff.synced && unit_ok && group_ok && mask_ok; // see (RULE12)
	assign q_full   = &s_ff.q_vld;
	assign q_idle   = !(|s_ff.q_vld);

	// Free entries, shown in status
	always_comb begin
		free_cnt = '0;
		for (int i = 0; i < QD; i++) begin
			free_cnt = free_cnt + {31'h0000_0000, !s_ff.q_vld[i]};
		end
	end

	assign wr_fire = s_ff.aw_hold && s_ff.w_hold && !s_ff.bvalid;
	assign wr_ofs  = {s_ff.aw_addr[7:2], 2'b00};
	assign rd_ofs  = {s_axi_araddr[7:2], 2'b00};

	// Next-state logic for bus, time base, sync exchange and queue
	always_comb begin
		logic [63:0] fwd;
		logic [63:0] bwd;
		logic [63:0] ofs;
		logic        placed;
		fwd    = '0;
		bwd    = '0;
		ofs    = '0;
		placed = 1'b0;
		nxt_s  = s_ff;
		nxt_s.expose = 1'b0;
		nxt_s.dreq   = 1'b0;
		nxt_s.now    = s_ff.now + NS_STEP;

		// Write address and data are taken in either order
		if (s_axi_awvalid && !s_ff.aw_hold) begin
			nxt_s.aw_hold = 1'b1;
			nxt_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_ff.w_hold) begin
			nxt_s.w_hold = 1'b1;
			nxt_s.w_data = s_axi_wdata;
			nxt_s.w_strb = s_axi_wstrb;
		end
		if (s_ff.bvalid && s_axi_bready) begin
			nxt_s.bvalid = 1'b0;
		end
		if (wr_fire) begin
			nxt_s.aw_hold = 1'b0;
			nxt_s.w_hold  = 1'b0;
			nxt_s.bvalid  = 1'b1;
			nxt_s.bresp   = RESP_OKAY;
			case (wr_ofs)
				OFS_CTRL: begin
					if (s_ff.w_strb[0]) begin
						nxt_s.sync_en = s_ff.w_data[BIT_SYNC_EN];
						if (s_ff.w_data[BIT_CLEAR]) begin
							nxt_s.now = '0; // see (RULE16)
						end
						if (s_ff.w_data[BIT_CAPTURE]) begin
							nxt_s.captured = s_ff.now; // see (RULE17)
						end
					end
				end
				OFS_UNIT_KEY:  nxt_s.unit_key = acp_merge(s_ff.unit_key, s_ff.w_data, s_ff.w_strb);
				OFS_GRP_KEY:   nxt_s.grp_key  = acp_merge(s_ff.grp_key, s_ff.w_data, s_ff.w_strb);
				OFS_GRP_MASK:  nxt_s.grp_mask = acp_merge(s_ff.grp_mask, s_ff.w_data, s_ff.w_strb);
				OFS_OWN_QUAL: begin
					if (s_ff.w_strb[0]) begin
						nxt_s.own_qual = s_ff.w_data[7:0];
					end
				end
				// Index is fixed; the write completes but stores nothing
				OFS_ENTRY_IDX: nxt_s.bresp = RESP_OKAY; // see (RULE3)
				OFS_STATUS, OFS_Q_DEPTH, OFS_CAP_LO, OFS_CAP_HI,
				OFS_PATH_DLY, OFS_DROP_CNT: nxt_s.bresp = RESP_OKAY;
				default: nxt_s.bresp = RESP_SLVERR;
			endcase
		end

		// Read path, one word per request
		if (s_ff.rvalid && s_axi_rready) begin
			nxt_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_ff.rvalid) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp  = RESP_OKAY;
			case (rd_ofs)
				OFS_CTRL:      nxt_s.rdata = {31'h0000_0000, s_ff.sync_en};
				OFS_STATUS:    nxt_s.rdata = {free_cnt[15:0], 13'h0000, s_ff.st,
					master_role};
				OFS_UNIT_KEY:  nxt_s.rdata = s_ff.unit_key;
				OFS_GRP_KEY:   nxt_s.rdata = s_ff.grp_key;
				OFS_GRP_MASK:  nxt_s.rdata = s_ff.grp_mask;
				OFS_ENTRY_IDX: nxt_s.rdata = 32'h0000_0000;          // see (RULE3)
				OFS_Q_DEPTH:   nxt_s.rdata = 32'(QD);                // see (RULE4)
				OFS_CAP_LO:    nxt_s.rdata = s_ff.captured[31:0];
				OFS_CAP_HI:    nxt_s.rdata = s_ff.captured[63:32];
				OFS_OWN_QUAL:  nxt_s.rdata = {24'h00_0000, s_ff.own_qual};
				OFS_PATH_DLY:  nxt_s.rdata = s_ff.path_dly;
				OFS_DROP_CNT:  nxt_s.rdata = s_ff.drop_cnt;
				default: begin
					nxt_s.rdata = 32'h0000_0000;
					nxt_s.rresp = RESP_SLVERR;
				end
			endcase
		end

		// Keep the best foreign clock seen so far
		if (ann_valid && (!s_ff.best_vld ||
			acp_better(ann_quality, ann_mac, s_ff.best_qual, s_ff.best_mac))) begin
			nxt_s.best_vld  = 1'b1; // see (RULE6) (RULE7)
			nxt_s.best_qual = ann_quality;
			nxt_s.best_mac  = ann_mac;
		end

		// Periodic delay exchange as slave; a master is its own reference
		if (!s_ff.sync_en) begin
			nxt_s.st         = ACP_IDLE; // see (RULE11)
			nxt_s.synced     = 1'b0;
			nxt_s.period_cnt = '0;
		end else if (master_role) begin
			nxt_s.st     = ACP_IDLE;
			nxt_s.synced = 1'b1; // see (RULE5)
		end else begin
			nxt_s.period_cnt = (s_ff.period_cnt == 32'(PERIOD_CYC - 1)) ? '0
				: s_ff.period_cnt + 32'h0000_0001;
			case (s_ff.st)
				ACP_IDLE: begin
					if (s_ff.period_cnt == '0) begin
						nxt_s.st = ACP_WAIT_SYNC; // see (RULE10)
					end
				end
				ACP_WAIT_SYNC: begin
					if (sync_valid) begin
						nxt_s.t1   = sync_origin;
						nxt_s.t2   = s_ff.now;
						nxt_s.t3   = s_ff.now;
						nxt_s.dreq = 1'b1; // see (RULE8)
						nxt_s.st   = ACP_WAIT_RESP;
					end
				end
				ACP_WAIT_RESP: begin
					if (resp_valid) begin
						// Half the difference of the two legs is our offset
						fwd = s_ff.t2 - s_ff.t1;
						bwd = s_ff.t3 - resp_time;
						fwd = fwd + bwd;
						ofs = {fwd[63], fwd[63:1]};
						bwd = (s_ff.t2 - s_ff.t1) - (s_ff.t3 - resp_time);
						nxt_s.path_dly = 32'(bwd >> 1);              // see (RULE8)
						nxt_s.now      = s_ff.now + NS_STEP - ofs;  // see (RULE9)
						nxt_s.synced   = 1'b1;
						nxt_s.st       = ACP_IDLE;
					end
				end
				default: nxt_s.st = ACP_IDLE;
			endcase
		end

		// Due entries fire; several at once give one exposure
		for (int i = 0; i < QD; i++) begin
			if (s_ff.q_vld[i] && acp_reached(s_ff.now, s_ff.q_time[i])) begin
				nxt_s.q_vld[i] = 1'b0; // see (RULE14)
				nxt_s.expose   = 1'b1;
			end
		end

		// Accepted commands: at once, queued, or dropped when full
		if (acc && !cmd_has_time) begin
			nxt_s.expose = 1'b1; // see (RULE13)
		end else if (acc && q_full) begin
			nxt_s.drop_cnt = s_ff.drop_cnt + 32'h0000_0001; // see (RULE19)
		end else if (acc) begin
			for (int i = 0; i < QD; i++) begin
				if (!s_ff.q_vld[i] && !placed) begin
					nxt_s.q_vld[i]  = 1'b1; // see (RULE14)
					nxt_s.q_time[i] = cmd_time;
					placed          = 1'b1;
				end
			end
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (srst) begin
			s_ff          <= '0;
			s_ff.st       <= ACP_IDLE;
			s_ff.unit_key <= RST_KEY;
			s_ff.grp_key  <= RST_KEY;
			s_ff.own_qual <= RST_OWN_QUAL;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Handshakes from state, data from flops
	assign s_axi_awready  = !s_ff.aw_hold;
	assign s_axi_wready   = !s_ff.w_hold;
	assign s_axi_bvalid   = s_ff.bvalid;
	assign s_axi_bresp    = s_ff.bresp;
	assign s_axi_arready  = !s_ff.rvalid;
	assign s_axi_rvalid   = s_ff.rvalid;
	assign s_axi_rdata    = s_ff.rdata;
	assign s_axi_rresp    = s_ff.rresp;
	assign delay_req_send = s_ff.dreq;
	assign action_ready   = s_ff.synced;
	assign exposure_start = s_ff.expose;
	assign is_master      = master_role;
	assign time_now       = s_ff.now;

	// Checks
	property p_group_key;
		@(posedge clock) disable iff (srst)
		cmd_valid && (cmd_group_key != s_ff.grp_key) && q_idle |=> !exposure_start && q_idle;
	endproperty
	a_group_key: assert property (p_group_key) else $error("group key mismatch accepted"); // see (RULE1)

	property p_mask;
		@(posedge clock) disable iff (srst)
		cmd_valid && ((cmd_group_mask & s_ff.grp_mask) == 32'h0000_0000) && q_idle
		|=> !exposure_start && q_idle;
	endproperty
	a_mask: assert property (p_mask) else $error("empty mask overlap accepted"); // see (RULE2)

	property p_unit_key;
		@(posedge clock) disable iff (srst)
		cmd_valid && (cmd_unit_key != s_ff.unit_key) && q_idle |=> !exposure_start && q_idle;
	endproperty
	a_unit_key: assert property (p_unit_key) else $error("unit key mismatch accepted"); // see (RULE18)

	sequence s_untimed_ok;
		cmd_valid && !cmd_has_time && action_ready && unit_ok && group_ok && mask_ok;
	endsequence
	property p_immediate;
		@(posedge clock) disable iff (srst)
		s_untimed_ok |=> exposure_start;
	endproperty
	a_immediate: assert property (p_immediate) else $error("untimed command did not expose"); // see (RULE13)

	property p_ready;
		@(posedge clock) disable iff (srst)
		!action_ready && cmd_valid && q_idle |=> !exposure_start && q_idle;
	endproperty
	a_ready: assert property (p_ready) else $error("command accepted before sync"); // see (RULE12)

	property p_clear;
		@(posedge clock) disable iff (srst)
		wr_fire && (wr_ofs == OFS_CTRL) && s_ff.w_strb[0] && s_ff.w_data[BIT_CLEAR]
		&& (s_ff.st == ACP_IDLE) |=> (time_now == 64'h0) ##1 (time_now == NS_STEP);
	endproperty
	a_clear: assert property (p_clear) else $error("time counter not cleared"); // see (RULE16)

	property p_capture;
		@(posedge clock) disable iff (srst)
		wr_fire && (wr_ofs == OFS_CTRL) && s_ff.w_strb[0] && s_ff.w_data[BIT_CAPTURE]
		|=> (s_ff.captured == $past(s_ff.now));
	endproperty
	a_capture: assert property (p_capture) else $error("capture value wrong"); // see (RULE17)

	property p_index_zero;
		@(posedge clock) disable iff (srst)
		s_axi_arvalid && s_axi_arready && (rd_ofs == OFS_ENTRY_IDX)
		|=> s_axi_rvalid && (s_axi_rdata == 32'h0000_0000);
	endproperty
	a_index_zero: assert property (p_index_zero) else $error("entry index not zero"); // see (RULE3)

	property p_full_drop;
		@(posedge clock) disable iff (srst)
		acc && cmd_has_time && q_full |=> (s_ff.drop_cnt == $past(s_ff.drop_cnt) + 32'h1);
	endproperty
	a_full_drop: assert property (p_full_drop) else $error("full queue did not drop"); // see (RULE19)

	property p_disabled_idle;
		@(posedge clock) disable iff (srst)
		!s_ff.sync_en |=> (s_ff.st == ACP_IDLE) && !delay_req_send && !action_ready;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle) else $error("sync active while off"); // see (RULE11)

endmodule

`default_nettype wire

// ---- test/acp_ptp_model.sv ----
// Behavioural time master on the far side of the link.
// Assumes it shares the system clock with the block and sees its requests.
`timescale 1ns/100ps
`default_nettype none

module acp_ptp_model #(
	parameter logic [63:0] OFS = 64'h0000_0000_0100_0000,
	parameter logic [63:0] DLY = 64'h0000_0000_0000_0190
) (
	// System side
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        slow,
	// Link messages
	input  wire logic        delay_req_send,
	output logic             sync_valid = 1'b0,
	output logic [63:0]      sync_origin = 64'h0,
	output logic             resp_valid = 1'b0,
	output logic [63:0]      resp_time = 64'h0
);
	logic [63:0] mt_ff = 64'h0;
	logic [63:0] t1_ff = 64'h0;
	logic [63:0] t4_ff = 64'h0;
	logic [3:0]  gap_ff = 4'h0;
	logic [3:0]  wait_ff = 4'h0;
	logic        pend_ff = 1'b0;

	// Free master time, a sync every 16 cycles, one reply per request
	always @(posedge clock) begin
		sync_valid  <= 1'b0;
		resp_valid  <= 1'b0;
		sync_origin <= ~sync_origin; // Idle payload keeps changing
		resp_time   <= ~resp_time;
		mt_ff       <= mt_ff + 64'h32;
		gap_ff      <= gap_ff + 4'h1;
		if (gap_ff == 4'hF) begin
			sync_valid  <= 1'b1;
			sync_origin <= mt_ff + 64'h32;
			t1_ff       <= mt_ff + 64'h32;
		end
		// Slow replies stress the wait for the answer
		if (delay_req_send) begin
			pend_ff <= 1'b1;
			wait_ff <= slow ? 4'h8 : 4'h0;
			t4_ff   <= t1_ff + DLY;
		end else if (pend_ff && wait_ff != 4'h0) begin
			wait_ff <= wait_ff - 4'h1;
		end else if (pend_ff) begin
			pend_ff    <= 1'b0;
			resp_valid <= 1'b1;
			resp_time  <= t4_ff;
		end
		if (srst) begin
			mt_ff   <= OFS;
			gap_ff  <= 4'h0;
			pend_ff <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// ---- test/acp_sched_test.sv ----
// Self-checking bench for the action-command scheduler.
// Assumes the time master model and the package from the core folder.
`timescale 1ns/100ps
`default_nettype none

module acp_sched_test;
	import acp_pkg::*;
	localparam int          QD      = 4;
	localparam logic [63:0] OFS     = 64'h0000_0000_0100_0000;
	localparam logic [63:0] DLY     = 64'h0000_0000_0000_0190;
	localparam logic [47:0] OWN_MAC = 48'h0000_1000_0000;
	localparam logic [31:0] UK      = 32'h5A5A_0001;
	localparam logic [31:0] GK      = 32'h0000_00C3;
	localparam logic [31:0] GM      = 32'h8000_00F0;
	// Bench-driven inputs
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic        slow = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        ann_valid = 1'b0;
	logic [7:0]  ann_quality = 8'h00;
	logic [47:0] ann_mac = 48'h0;
	logic        cmd_valid = 1'b0;
	logic        cmd_has_time = 1'b0;
	logic [31:0] cmd_unit_key = 32'h0;
	logic [31:0] cmd_group_key = 32'h0;
	logic [31:0] cmd_group_mask = 32'h0;
	logic [63:0] cmd_time = 64'h0;
	// Outputs of the block and the model
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        sync_valid, resp_valid, delay_req_send;
	logic        action_ready, exposure_start, is_master;
	logic [63:0] sync_origin, resp_time, time_now;
	int          failures = 0;
	int          tests_run = 0;

	// Short exchange period keeps the run brief
	acp_sched #(.QD(QD), .PERIOD_CYC(16)) uut (
		.clock, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ann_valid, .ann_quality, .ann_mac,
		.own_mac(OWN_MAC), .sync_valid, .sync_origin, .resp_valid, .resp_time,
		.delay_req_send, .cmd_valid, .cmd_unit_key, .cmd_group_key, .cmd_group_mask,
		.cmd_has_time, .cmd_time, .action_ready, .exposure_start, .is_master, .time_now
	);
	acp_ptp_model #(.OFS(OFS), .DLY(DLY)) master (
		.clock, .srst, .slow, .delay_req_send, .sync_valid, .sync_origin,
		.resp_valid, .resp_time
	);

	// Free-running clock
	always #(CLK_PERIOD_NS / 2) clock = ~clock;

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One register access; each channel released at its own handshake
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er, output logic [31:0] q);
		logic       a_ok, w_ok, ra, rw;
		logic [1:0] rsp;
		a_ok = 1'b0;
		w_ok = !we;
		s_axi_awaddr  <= a;
		s_axi_araddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= we;
		s_axi_wvalid  <= we;
		s_axi_arvalid <= !we;
		s_axi_bready  <= we;
		s_axi_rready  <= !we;
		while (!(a_ok && w_ok)) begin
			@(negedge clock);
			ra = we ? s_axi_awready : s_axi_arready;
			rw = s_axi_wready;
			@(posedge clock);
			if (ra && !a_ok) begin
				s_axi_awvalid <= 1'b0;
				s_axi_arvalid <= 1'b0;
				a_ok = 1'b1;
			end
			if (rw && !w_ok) begin
				s_axi_wvalid <= 1'b0;
				w_ok = 1'b1;
			end
		end
		do begin
			@(negedge clock);
			ra  = we ? s_axi_bvalid : s_axi_rvalid;
			rsp = we ? s_axi_bresp : s_axi_rresp;
			q   = s_axi_rdata;
			@(posedge clock);
		end while (!ra);
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		@(posedge clock);
		chk(64'(ra), 64'h1);
		chk(64'(rsp), 64'(er));
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [31:0] q;
		bus(1'b1, a, d, er, q);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, er, q);
		chk(64'(q), 64'(e));
	endtask

	task automatic cmd(input logic [31:0] uk, input logic [31:0] gk, input logic [31:0] gm,
		input logic ht, input logic [63:0] t);
		cmd_unit_key   <= uk;
		cmd_group_key  <= gk;
		cmd_group_mask <= gm;
		cmd_has_time   <= ht;
		cmd_time       <= t;
		cmd_valid      <= 1'b1;
		@(posedge clock);
		cmd_valid <= 1'b0;
	endtask

	// Untimed command; a pulse is one cycle long when it comes
	task automatic cmd_now(input logic [31:0] uk, input logic [31:0] gk,
		input logic [31:0] gm, input logic e);
		cmd(uk, gk, gm, 1'b0, 64'h0);
		@(negedge clock);
		chk(64'(exposure_start), 64'(e));
		@(negedge clock);
		chk(64'(exposure_start), 64'h0);
		@(posedge clock);
	endtask

	task automatic ann(input logic [7:0] qu, input logic [47:0] mac, input logic e);
		ann_quality <= qu;
		ann_mac     <= mac;
		ann_valid   <= 1'b1;
		@(posedge clock);
		ann_valid <= 1'b0;
		repeat (2) @(negedge clock);
		chk(64'(is_master), 64'(e));
		@(posedge clock);
	endtask

	task automatic t_regs;
		rchk(OFS_UNIT_KEY, RST_KEY, RESP_OKAY);
		rchk(OFS_GRP_MASK, 32'h0, RESP_OKAY);
		s_axi_wstrb <= 4'h3;
		wr(OFS_GRP_MASK, 32'hFFFF_FFFF, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rchk(OFS_GRP_MASK, 32'h0000_FFFF, RESP_OKAY);
		rchk(OFS_OWN_QUAL, 32'(RST_OWN_QUAL), RESP_OKAY);
		wr(OFS_Q_DEPTH, 32'h55, RESP_OKAY);
		rchk(OFS_Q_DEPTH, 32'(QD), RESP_OKAY);
		wr(OFS_ENTRY_IDX, 32'h3, RESP_OKAY);
		rchk(OFS_ENTRY_IDX, 32'h0, RESP_OKAY);
		wr(8'h30, 32'h1, RESP_SLVERR);
		rchk(8'h30, 32'h0, RESP_SLVERR);
	endtask

	// Capture must hold still while the counter runs on
	task automatic t_time;
		logic [31:0] lo, hi, lo2;
		repeat (40) @(posedge clock);
		wr(OFS_CTRL, 32'h4, RESP_OKAY);
		bus(1'b0, OFS_CAP_LO, 32'h0, RESP_OKAY, lo);
		bus(1'b0, OFS_CAP_HI, 32'h0, RESP_OKAY, hi);
		bus(1'b0, OFS_CAP_LO, 32'h0, RESP_OKAY, lo2);
		chk(64'(lo2), 64'(lo));
		chk(64'({hi, lo} > 64'h7D0), 64'h1);
		wr(OFS_CTRL, 32'h2, RESP_OKAY);
		wr(OFS_CTRL, 32'h4, RESP_OKAY);
		bus(1'b0, OFS_CAP_LO, 32'h0, RESP_OKAY, lo);
		bus(1'b0, OFS_CAP_HI, 32'h0, RESP_OKAY, hi);
		chk(64'({hi, lo} < 64'h258), 64'h1);
	endtask

	task automatic t_role;
		wr(OFS_CTRL, 32'h1, RESP_OKAY);
		repeat (3) @(negedge clock);
		chk(64'(action_ready), 64'h1);
		@(posedge clock);
		wr(OFS_CTRL, 32'h0, RESP_OKAY);
		@(negedge clock);
		chk(64'(action_ready), 64'h0);
		@(posedge clock);
		ann(8'hF0, OWN_MAC - 48'h1, 1'b1);
		ann(RST_OWN_QUAL, OWN_MAC + 48'h1, 1'b1);
		ann(RST_OWN_QUAL, OWN_MAC - 48'h1, 1'b0);
	endtask

	// Slave: nothing while disabled, then the exchange locks and repeats
	task automatic t_sync;
		int dq;
		int n;
		dq = 0;
		n  = 0;
		wr(OFS_UNIT_KEY, UK, RESP_OKAY);
		wr(OFS_GRP_KEY, GK, RESP_OKAY);
		wr(OFS_GRP_MASK, GM, RESP_OKAY);
		rchk(OFS_GRP_MASK, GM, RESP_OKAY);
		cmd_now(UK, GK, GM, 1'b0);
		repeat (60) begin
			@(negedge clock);
			dq += int'(delay_req_send);
		end
		chk(64'(dq), 64'h0);
		@(posedge clock);
		wr(OFS_CTRL, 32'h1, RESP_OKAY);
		while (action_ready !== 1'b1 && n < 200) begin
			@(negedge clock);
			n++;
		end
		chk(64'(action_ready), 64'h1);
		chk(64'(time_now >= OFS), 64'h1);
		@(posedge clock);
		rchk(OFS_PATH_DLY, 32'(DLY >> 1), RESP_OKAY);
		slow <= 1'b1;
		dq = 0;
		repeat (100) begin
			@(negedge clock);
			dq += int'(delay_req_send);
		end
		@(posedge clock);
		chk(64'(dq >= 2), 64'h1);
	endtask

	task automatic t_cmd;
		logic [63:0] t, hit;
		int          seen;
		cmd_now(UK, GK, GM, 1'b1);
		cmd_now(~UK, GK, GM, 1'b0);
		cmd_now(UK, ~GK, GM, 1'b0);
		cmd_now(UK, GK, ~GM, 1'b0);
		cmd_now(UK, GK, 32'h8000_0000, 1'b1);
		@(negedge clock);
		t    = time_now + 64'h3E8;
		seen = 0;
		@(posedge clock);
		cmd(UK, GK, GM, 1'b1, t);
		repeat (40) begin
			@(negedge clock);
			if (exposure_start) begin
				seen++;
				hit = time_now;
			end
		end
		@(posedge clock);
		chk(64'(seen), 64'h1);
		chk(64'(hit >= t && hit <= t + 64'h64), 64'h1);
	endtask

	// Fill past depth; the late arrival is the earliest and must not fire
	task automatic t_queue;
		logic [63:0] b;
		logic [31:0] q;
		int          seen, early;
		@(negedge clock);
		b     = time_now + 64'hBB8;
		seen  = 0;
		early = 0;
		@(posedge clock);
		for (int i = 0; i <= QD; i++) begin
			cmd_time  <= (i < QD) ? b + 64'(i * 500) : b - 64'h5DC;
			cmd_valid <= 1'b1;
			@(posedge clock);
		end
		cmd_valid <= 1'b0;
		bus(1'b0, OFS_STATUS, 32'h0, RESP_OKAY, q);
		chk(64'(q[31:16]), 64'h0);
		rchk(OFS_DROP_CNT, 32'h1, RESP_OKAY);
		repeat (150) begin
			@(negedge clock);
			seen += int'(exposure_start);
			early += int'(exposure_start && time_now < b);
		end
		@(posedge clock);
		chk(64'(seen), 64'(QD));
		chk(64'(early), 64'h0);
		bus(1'b0, OFS_STATUS, 32'h0, RESP_OKAY, q);
		chk(64'(q[31:16]), 64'(QD));
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		t_regs;
		t_time;
		t_role;
		t_sync;
		t_cmd;
		t_queue;
		close_out;
	end

	// Watchdog far beyond the expected run length
	initial begin
		#(CLK_PERIOD_NS * 20000);
		failures++;
		close_out;
	end
endmodule

`default_nettype wire
